/* design/dwdt_map.vh */
// constants for the digital watchdog timer: register map, fields, reset values, timing
// assumes a wishbone classic slave with 8-bit registers in the low byte of each word
`ifndef DWDT_MAP_VH
`define DWDT_MAP_VH

// ==========================================
// register map
`define DWDT_ADDR_COUNT 8'hd8
`define DWDT_COUNT_RESET 8'hfe

// ==========================================
// fields
`define DWDT_BIT_ARM 0
`define DWDT_BIT_SWRST 1
`define DWDT_PERIOD_LO 2
`define DWDT_PERIOD_HI 7

// ==========================================
// timing
`define DWDT_TICK_DIV 12
`define DWDT_STEP_TICKS 256
`define DWDT_RESET_HOLD 2048
`define DWDT_CPU_DIV 13
`define DWDT_GUARD_INSTR 28
`define DWDT_MIN_CYCLES_PER_INSTR 2

`endif

/* design/dwdt_tick_div.v */
// divider producing a one-cycle enable every DIV clocks
// assumes the clock is the internal clock of the device
`timescale 1ns/1ps
module dwdt_tick_div #(
	parameter DIV = 12
) (
	input wire clk_i,
	input wire rst_i,
	input wire run_i,
	output wire tick_o
);
	reg [7:0] cnt_r;

	// frozen while run_i is low so a held count stays exactly where it stopped
	always @(posedge clk_i) begin
		if (rst_i) begin
			cnt_r <= 8'h00;
		end else if (run_i) begin
			if (cnt_r == DIV - 1) begin
				cnt_r <= 8'h00;
			end else begin
				cnt_r <= cnt_r + 8'h01;
			end
		end
	end

	assign tick_o = run_i && (cnt_r == DIV - 1);
endmodule // dwdt_tick_div

/* design/dwdt_reset_hold.v */
// stretches a reset request into a hold of HOLD clocks
// assumes requests are single-clock or level; the hold restarts on every request
`timescale 1ns/1ps
module dwdt_reset_hold #(
	parameter HOLD = 2048
) (
	input wire clk_i,
	input wire rst_i,
	input wire req_i,
	output wire hold_o
);
	// power-up value: rst_i is not wired here, so the hold must not start unknown
	reg [11:0] cnt_r = 12'h000;

	always @(posedge clk_i) begin
		if (rst_i) begin
			cnt_r <= 12'h000;
		end else if (req_i) begin
			cnt_r <= HOLD[11:0] - 12'h001;
		end else if (cnt_r != 12'h000) begin
			cnt_r <= cnt_r - 12'h001;
		end
	end

	assign hold_o = req_i || (cnt_r != 12'h000);
endmodule // dwdt_reset_hold

/* design/dwdt_top.v */
// digital watchdog timer: reloadable downcounter with wishbone register access
// assumes the core raises stop_req_i for one clock per stop instruction, and that
// wake_i marks the interrupt that leaves stop mode; mcu_rst_o must feed back into rst_i
`timescale 1ns/1ps
`include "dwdt_map.vh"
module dwdt_top #(
	parameter HW_ACTIVATION = 1'b0,
	parameter EXT_STOP_CTRL = 1'b0,
	parameter TICK_DIV = `DWDT_TICK_DIV,
	parameter RESET_HOLD = `DWDT_RESET_HOLD,
	parameter GUARD_TICKS = 4
) (
	input wire clk_i,
	input wire rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	output wire wb_err_o,
	input wire stop_req_i,
	input wire prio_wake_i,
	input wire wake_i,
	output reg stop_mode_o,
	output reg wait_mode_o,
	output reg osc_halt_o,
	output wire wd_active_o,
	output wire mcu_rst_o
);
	// ==========================================
	// functions
	function [5:0] dwdt_rev6;
		input [5:0] v;
		integer k;
		begin
			for (k = 0; k < 6; k = k + 1) begin
				dwdt_rev6[k] = v[5 - k];
			end
		end
	endfunction

	// ==========================================
	// state
	reg armed_r;
	reg [6:0] cnt_r; // physical counter: [6] software reset bit, [5:0] period lsb..msb
	reg [7:0] shadow_r;
	reg load_pend_r;
	reg [7:0] guard_r;
	reg wd_fire_r;
	// one counter step spans 256 time-base ticks, so the shortest period is 3072 clocks
	localparam STEP_TICKS = `DWDT_STEP_TICKS;
	reg [7:0] pre_r;
	wire tick;
	wire running;
	wire hold;
	wire wr_hit;
	wire rd_hit;
	wire req;
	wire armed_eff;

	assign armed_eff = HW_ACTIVATION ? 1'b1 : armed_r;
	assign wd_active_o = armed_eff;
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_hit = req && wb_we_i && (wb_adr_i == `DWDT_ADDR_COUNT) && wb_sel_i[0];
	assign rd_hit = req && !wb_we_i && (wb_adr_i == `DWDT_ADDR_COUNT);
	// unmapped addresses still get ack with zero data; no error path
	assign wb_err_o = 1'b0;

	// ==========================================
	// stop / wait handling
	// counter freezes only in true stop; wait keeps the oscillator and count alive
	assign running = !stop_mode_o;

	always @(posedge clk_i) begin
		if (rst_i) begin
			stop_mode_o <= 1'b0;
			wait_mode_o <= 1'b0;
			osc_halt_o <= 1'b0;
		end else if (stop_mode_o || wait_mode_o) begin
			if (wake_i) begin
				stop_mode_o <= 1'b0;
				wait_mode_o <= 1'b0;
				osc_halt_o <= 1'b0;
			end
		end else if (stop_req_i) begin
			if (!armed_eff) begin
				stop_mode_o <= 1'b1;
				osc_halt_o <= 1'b1;
			end else if (EXT_STOP_CTRL && prio_wake_i) begin
				stop_mode_o <= 1'b1;
				osc_halt_o <= 1'b1;
			end else begin
				wait_mode_o <= 1'b1;
			end
		end
	end

	dwdt_tick_div #(
		.DIV(TICK_DIV)
	) u_div (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.run_i(running),
		.tick_o(tick)
	);

	// ==========================================
	// register, counter and reset generation
	always @(posedge clk_i) begin
		if (rst_i) begin
			armed_r <= 1'b0;
			cnt_r <= 7'h7f;
			shadow_r <= `DWDT_COUNT_RESET;
			load_pend_r <= 1'b0;
			guard_r <= GUARD_TICKS[7:0];
			wd_fire_r <= 1'b0;
			pre_r <= 8'h00;
		end else begin
			wd_fire_r <= 1'b0;
			if (wr_hit) begin
				shadow_r <= wb_dat_i[7:0];
				load_pend_r <= 1'b1;
				if (wb_dat_i[`DWDT_BIT_ARM] && !armed_r) begin
					armed_r <= 1'b1;
					guard_r <= GUARD_TICKS[7:0];
				end
				if (!wb_dat_i[`DWDT_BIT_SWRST]) begin
					wd_fire_r <= 1'b1;
				end
			end
			if (tick) begin
				if (guard_r != 8'h00) begin
					guard_r <= guard_r - 8'h01;
				end
				if (load_pend_r && !wr_hit) begin
					cnt_r <= {shadow_r[`DWDT_BIT_SWRST], dwdt_rev6(shadow_r[`DWDT_PERIOD_HI:`DWDT_PERIOD_LO])};
					load_pend_r <= 1'b0;
					// reload restarts the whole step so the full period is granted
					pre_r <= 8'h00;
				end else if (pre_r == STEP_TICKS - 1) begin
					pre_r <= 8'h00;
					cnt_r <= cnt_r - 7'h01;
					// bit 6 falling to zero ends the count
					if (armed_eff && cnt_r == 7'h40 && guard_r == 8'h00) begin
						wd_fire_r <= 1'b1;
					end
				end else begin
					pre_r <= pre_r + 8'h01;
				end
			end
		end
	end

	dwdt_reset_hold #(
		.HOLD(RESET_HOLD)
	) u_hold (
		.clk_i(clk_i),
		.rst_i(1'b0),
		.req_i(wd_fire_r),
		.hold_o(hold)
	);
	assign mcu_rst_o = hold;

	// ==========================================
	// bus answer: one-cycle registered ack
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= 32'h00000000;
			if (rd_hit) begin
				// readback shows the live counter in register bit order
				wb_dat_o[7:0] <= {dwdt_rev6(cnt_r[5:0]), cnt_r[6], armed_eff};
			end
		end
	end
endmodule // dwdt_top

/* tb/dwdt_monitor.sv */
// port checker for the watchdog top
// assumes bind onto dwdt_top, software activation, no external stop control
`timescale 1ns/1ps
module dwdt_monitor (
	input wire clk_i,
	input wire rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	input wire stop_req_i,
	input wire wake_i,
	input wire stop_mode_o,
	input wire wait_mode_o,
	input wire osc_halt_o,
	input wire wd_active_o,
	input wire mcu_rst_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire req = wb_cyc_i & wb_stb_i & !wb_ack_o;
	wire clr_sr = req & wb_we_i & wb_sel_i[0] & (wb_adr_i == 8'hd8) & !wb_dat_i[1];
	property p_ack; req |=> wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack missing");
	property p_ack_drop; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_drop: assert property (p_ack_drop) else $error("ack too long");
	property p_hi; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
	a_hi: assert property (p_hi) else $error("upper data set");
	property p_sr; clr_sr |-> ##[1:3] mcu_rst_o; endproperty
	a_sr: assert property (p_sr) else $error("no software reset");
	property p_hold; $rose(mcu_rst_o) |-> mcu_rst_o [*8]; endproperty
	a_hold: assert property (p_hold) else $error("reset too short");
	property p_arm; wd_active_o |=> wd_active_o; endproperty
	a_arm: assert property (p_arm) else $error("disarmed");
	property p_stop; stop_req_i & !wd_active_o & !wake_i |=> stop_mode_o & osc_halt_o; endproperty
	a_stop: assert property (p_stop) else $error("no stop");
	property p_wait; stop_req_i & wd_active_o & !wake_i |=> wait_mode_o & !stop_mode_o; endproperty
	a_wait: assert property (p_wait) else $error("no wait");
	property p_wake; wake_i & !stop_req_i |=> !stop_mode_o & !wait_mode_o; endproperty
	a_wake: assert property (p_wake) else $error("no wake");
	c_stop: cover property (stop_req_i ##1 stop_mode_o);
	c_wait: cover property (stop_req_i ##1 wait_mode_o);
	c_rst: cover property ($rose(mcu_rst_o));
endmodule // dwdt_monitor
bind dwdt_top dwdt_monitor dwdt_monitor_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
	.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .stop_req_i, .wake_i, .stop_mode_o, .wait_mode_o,
	.osc_halt_o, .wd_active_o, .mcu_rst_o);

/* tb/digital_watchdog_timer_tb.sv */
// bench for the watchdog top over wishbone
// assumes short reset hold, no guard; reset is not fed back
`timescale 1ns/1ps
module digital_watchdog_timer_tb;
	reg clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, sreq = 0, wk = 0;
	reg [7:0] adr = 0;
	reg [31:0] dat = 0, rd;
	wire [31:0] dat_o;
	wire ack, stp, wt, osc, act, mrst;
	integer n_fail = 0, n_compared = 0, n;
	always #2.5 clk_i = ~clk_i;
	dwdt_top #(.RESET_HOLD(16), .GUARD_TICKS(0)) dwdt_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .wb_err_o(), .stop_req_i(sreq), .prio_wake_i(1'b0), .wake_i(wk), .stop_mode_o(stp),
		.wait_mode_o(wt), .osc_halt_o(osc), .wd_active_o(act), .mcu_rst_o(mrst));
	// ==========================================
	// tasks
	task chk(input [31:0] s, input [31:0] e, input [63:0] nm);
		begin
			n_compared = n_compared + 1;
			if (s !== e) begin
				n_fail = n_fail + 1;
				$display("[ERR] %0s exp %h seen %h", nm, e, s);
			end
		end
	endtask
	task bus(input w, input [7:0] a, input [7:0] d);
		begin
			@(posedge clk_i);
			cyc <= 1;
			stb <= 1;
			we <= w;
			adr <= a;
			dat <= {24'h0, d};
			// only the 100000 ns time limit ends a lost ack
			do @(posedge clk_i); while (ack !== 1'b1);
			rd = dat_o;
			cyc <= 0;
			stb <= 0;
		end
	endtask
	task pulse(input s);
		begin
			@(posedge clk_i);
			if (s) sreq <= 1;
			else wk <= 1;
			@(posedge clk_i);
			sreq <= 0;
			wk <= 0;
			@(posedge clk_i);
		end
	endtask
	task rst_pulse;
		begin
			rst_i <= 1;
			repeat (5) @(posedge clk_i);
			rst_i <= 0;
		end
	endtask
	task stop_test;
		begin
			$display("compared %0d failed %0d", n_compared, n_fail);
			if (n_fail == 0 && n_compared > 0) $display("Run complete: PASS");
			else $display("Run complete: FAIL");
			$finish;
		end
	endtask
	// ==========================================
	// tests
	initial begin
		#100000;
		n_fail = n_fail + 1;
		stop_test;
	end
	initial begin
		rst_pulse;
		bus(0, 8'hd8, 0);
		chk(rd, 32'hfe, "rstval");
		bus(0, 8'h10, 0);
		chk(rd, 32'h0, "unmap");
		chk(act, 0, "idle");
		pulse(1);
		chk({stp, osc}, 2'b11, "stop");
		pulse(0);
		chk(stp, 0, "wake");
		repeat (1600) @(posedge clk_i);
		chk(mrst, 0, "free");
		$display("test idle done");
		bus(1, 8'hd8, 8'h03);
		chk(act, 1, "armed");
		bus(1, 8'hd8, 8'h02);
		bus(0, 8'hd8, 0);
		chk(rd[0], 1, "keep");
		pulse(1);
		chk({wt, stp}, 2'b10, "wait");
		pulse(0);
		// shortest period: one step of the counter
		for (n = 0; mrst !== 1'b1 && n < 8000; n = n + 1) @(posedge clk_i);
		chk(mrst, 1, "expire");
		chk(n >= 3000, 1, "period");
		$display("test expire done");
		repeat (20) @(posedge clk_i);
		rst_pulse;
		chk(act, 0, "disarm");
		bus(1, 8'hd8, 8'h00);
		for (n = 0; mrst !== 1'b1 && n < 4; n = n + 1) @(posedge clk_i);
		chk(mrst, 1, "swrst");
		$display("test swrst done");
		stop_test;
	end
endmodule // digital_watchdog_timer_tb
